// ---- ddrci_pkg.sv ----
// Constants and types of the memory control-input block.
// Assumes one clock domain and an APB master with 32-bit data.
package ddrci_pkg;

  // ****************************************************************
  // Geometry of the 16-bit organisation
  // ****************************************************************
  localparam int unsigned NUM_BANKS  = 4;
  localparam int unsigned BANK_W     = 2;
  localparam int unsigned ROW_W      = 13;
  localparam int unsigned COL_W      = 10;
  localparam int unsigned PAGE_BYTES = 2048;
  localparam int unsigned DQ_W       = 16;
  localparam int unsigned AUTO_CLOSE_BIT = 10;

  // ****************************************************************
  // Extended setup write: bank code and termination fields
  // ****************************************************************
  localparam logic [1:0] EXT_SETUP_BANK = 2'h1;
  localparam int unsigned TERM_FIELD_LO = 2;
  localparam int unsigned TERM_FIELD_HI = 6;
  localparam logic        TERM_EN_RST   = 1'h0;

  // ****************************************************************
  // Register map (byte addresses) and field positions
  // ****************************************************************
  localparam int unsigned APB_AW       = 12;
  localparam logic [11:0] REG_STATUS   = 12'h000;
  localparam logic [11:0] REG_PATTERN  = 12'h004;
  localparam logic [11:0] REG_LAST_CMD = 12'h008;
  localparam logic [11:0] REG_ROW_BASE = 12'h010;
  localparam int unsigned ST_PWR_LO    = 0;
  localparam int unsigned ST_OPEN_LO   = 4;
  localparam int unsigned ST_EXT_TERM  = 8;
  localparam int unsigned ST_TERM_ON   = 9;
  localparam int unsigned LC_BANK_LO   = 16;
  localparam int unsigned LC_CMD_LO    = 20;
  localparam logic [31:0] PATTERN_RST  = 32'h0000_0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    PWR_RUN, PWR_PD_PRE, PWR_PD_ACT, PWR_SELF
  } ddrci_pwr_e;

  typedef enum logic [2:0] {
    CMD_DESEL, CMD_NOP, CMD_ACT, CMD_READ,
    CMD_WRITE, CMD_PRE, CMD_REF, CMD_SETUP
  } ddrci_cmd_e;

  typedef struct packed {
    logic              cke;
    logic              select_n;
    logic              row_strobe_n;
    logic              col_strobe_n;
    logic              write_en_n;
    logic              termination_control;
    logic [BANK_W-1:0] bank_select;
    logic [ROW_W-1:0]  addr;
  } ddrci_pins_s;

  typedef struct packed {
    logic [DQ_W-1:0] dq;
    logic [3:0]      strobe;
    logic [1:0]      mask;
  } ddrci_term_s;

endpackage : ddrci_pkg

// ---- ddrci_top.sv ----
// Control-input logic of a 16-bit double-data-rate memory device.
// Assumes memory pins arrive asynchronously and an APB master on core_clk.
//
// Operation
// - Capture all address and control inputs on the rising clock edge.
// - Read data leaves as two beats per clock, one per crossing.
// - Clock gate high runs clocks, buffers, drivers; low stops them.
// - Gate low enters precharge power-down or self refresh, else active.
// - Gate is sampled on the clock for power-down and refresh entry.
// - Self refresh exits on gate rising alone, needing no other input; here the exit waits for the synchronised gate on core_clk.
// - In power-down only clock and gate input buffers stay enabled.
// - In self refresh only the gate input buffer stays enabled.
// - Commands sampled with device select high are ignored.
// - Device select is decoded with the strobes into the command.
// - Termination control registered high enables on-die termination.
// - Only data, strobe and mask pins are ever terminated.
// - All data bits, both strobe pairs and both masks get termination.
// - Termination control is ignored when the setup write disables it.
// - Four banks, 13-bit row, 10-bit column, 2 KB page, bit 10 flag.
// - Strobes with device select encode the command each edge.
// - Precharge closes the chosen bank, or all banks with bit 10 high.
//
// Our own choices: the APB register port and the placing of the registers.
module ddrci_top
  import ddrci_pkg::*;
#(
  parameter int unsigned NBANK = NUM_BANKS
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire ddrci_pins_s       pins,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [31:0]            prdata,
  output logic                   clk_run,
  output logic                   cmd_buf_en,
  output logic                   clk_buf_en,
  output logic                   out_drv_en,
  output ddrci_term_s            term_en,
  output logic                   rd_valid,
  output logic [DQ_W-1:0]        rd_rise,
  output logic [DQ_W-1:0]        rd_fall
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    ddrci_pins_s                  s1;
    ddrci_pins_s                  s2;
    logic                         cke_prev;
    ddrci_pwr_e                   pwr;
    logic [NBANK-1:0]             open;
    logic [NBANK-1:0][ROW_W-1:0]  rows;
    logic                         ext_term;
    logic [31:0]                  pattern;
    ddrci_cmd_e                   last_cmd;
    logic [BANK_W-1:0]            last_bank;
    logic [ROW_W-1:0]             last_addr;
    logic                         pready;
    logic                         pslverr;
    logic [31:0]                  prdata;
    logic                         clk_run;
    logic                         cmd_buf;
    logic                         clk_buf;
    logic                         out_drv;
    ddrci_term_s                  term;
    logic                         rd_valid;
    logic [DQ_W-1:0]              rd_rise;
    logic [DQ_W-1:0]              rd_fall;
  } ddrci_state_s;

  // One packed record holds every flop of the block; st_d is its next value.
  ddrci_state_s st_q;
  ddrci_state_s st_d;

  // Register index of an APB address, or -1 when unmapped.
  function automatic int reg_index(input logic [APB_AW-1:0] a);
    int idx;
    idx = -1;
    if (a == REG_STATUS) begin
      idx = 0;
    end else if (a == REG_PATTERN) begin
      idx = 1;
    end else if (a == REG_LAST_CMD) begin
      idx = 2;
    end else if (a >= REG_ROW_BASE &&
                 a < REG_ROW_BASE + APB_AW'(4 * NBANK) &&
                 a[1:0] == 2'h0) begin
      idx = 3 + int'((a - REG_ROW_BASE) >> 2);
    end
    return idx;
  endfunction

  // Command code: device select together with the three strobes.
  function automatic ddrci_cmd_e ddrci_decode(input ddrci_pins_s p);
    ddrci_cmd_e c;
    c = CMD_NOP;
    if (p.select_n) begin
      c = CMD_DESEL;
    end else begin
      unique case ({p.row_strobe_n, p.col_strobe_n, p.write_en_n})
        3'h0: c = CMD_SETUP;
        3'h1: c = CMD_REF;
        3'h2: c = CMD_PRE;
        3'h3: c = CMD_ACT;
        3'h4: c = CMD_WRITE;
        3'h5: c = CMD_READ;
        3'h6: c = CMD_NOP;
        3'h7: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    ddrci_cmd_e        cmd;
    logic              cke;
    logic              fell;
    logic [BANK_W-1:0] bk;
    logic              run;
    logic              term_on;
    int                idx;
    logic [31:0]       rdv;
    st_d    = st_q;
    cmd     = CMD_NOP;
    bk      = st_q.s2.bank_select;
    cke     = st_q.s2.cke;
    fell    = st_q.cke_prev && !cke;
    run     = 1'b0;
    term_on = 1'b0;
    idx     = -1;
    rdv     = 32'h0000_0000;

    // Two-flop synchroniser on every memory pin. The pins come from the
    // controller's domain, so nothing but the second stage is decoded;
    // this costs two cycles of latency on every command and gate change.
    st_d.s1       = pins;
    st_d.s2       = st_q.s1;
    st_d.cke_prev = cke;
    st_d.rd_valid = 1'b0;

    // Gate level handling and power state; gate is sampled each edge.
    unique case (st_q.pwr)
      PWR_RUN: begin
        if (fell) begin
          if (st_q.open != '0) begin
            st_d.pwr = PWR_PD_ACT;
          end else if (ddrci_decode(st_q.s2) == CMD_REF) begin
            st_d.pwr = PWR_SELF;
          end else begin
            st_d.pwr = PWR_PD_PRE;
          end
        end
        run = cke;
      end
      PWR_PD_PRE, PWR_PD_ACT: begin
        if (cke) begin
          st_d.pwr = PWR_RUN;
        end
      end
      PWR_SELF: begin
        // Only the gate is looked at here, nothing else. The exit is taken
        // from the synchronised gate, so it still needs the core clock.
        if (cke) begin
          st_d.pwr = PWR_RUN;
        end
      end
    endcase

    // Command decode only while running; select high masks all.
    if (run) begin
      cmd = ddrci_decode(st_q.s2);
    end
    if (cmd != CMD_DESEL && cmd != CMD_NOP) begin
      st_d.last_cmd  = cmd;
      st_d.last_bank = bk;
      st_d.last_addr = st_q.s2.addr;
    end
    unique case (cmd)
      CMD_ACT: begin
        st_d.open[bk] = 1'b1;
        st_d.rows[bk] = st_q.s2.addr;
      end
      CMD_READ, CMD_WRITE: begin
        if (cmd == CMD_READ) begin
          st_d.rd_valid = 1'b1;
          st_d.rd_rise  = st_q.pattern[DQ_W-1:0];
          st_d.rd_fall  = st_q.pattern[31:DQ_W];
        end
        if (st_q.s2.addr[AUTO_CLOSE_BIT]) begin
          st_d.open[bk] = 1'b0;
        end
      end
      CMD_PRE: begin
        if (st_q.s2.addr[AUTO_CLOSE_BIT]) begin
          st_d.open = '0;
        end else begin
          st_d.open[bk] = 1'b0;
        end
      end
      CMD_SETUP: begin
        if (bk == EXT_SETUP_BANK) begin
          st_d.ext_term = st_q.s2.addr[TERM_FIELD_LO] |
                          st_q.s2.addr[TERM_FIELD_HI];
        end
      end
      default: begin
      end
    endcase

    // Buffer, driver and clock enables follow the power state.
    // The clock buffers stay on in power-down so that exit is seen.
    st_d.clk_run = run;
    st_d.out_drv = run;
    st_d.cmd_buf = run;
    st_d.clk_buf = (st_q.pwr != PWR_SELF);

    // Termination only on data, strobe and mask lanes.
    // Address, command and clock pins are never terminated, in any mode.
    term_on = run && st_q.ext_term &&
              st_q.s2.termination_control;
    st_d.term.dq     = {DQ_W{term_on}};
    st_d.term.strobe = {4{term_on}};
    st_d.term.mask   = {2{term_on}};

    // APB slave: answer in the first access cycle. A write lands at the edge
    // where the master samples pready, never on a setup that is withdrawn.
    st_d.pready  = 1'b0;
    st_d.pslverr = 1'b0;
    if (psel && !penable) begin
      idx = reg_index(paddr);
      unique case (idx)
        -1: rdv = 32'h0000_0000;
        0: begin
          rdv[ST_PWR_LO +: 2]      = st_q.pwr;
          rdv[ST_OPEN_LO +: NBANK] = st_q.open;
          rdv[ST_EXT_TERM]         = st_q.ext_term;
          rdv[ST_TERM_ON]          = st_q.term.mask[0];
        end
        1: rdv = st_q.pattern;
        2: begin
          rdv[ROW_W-1:0]           = st_q.last_addr;
          rdv[LC_BANK_LO +: BANK_W] = st_q.last_bank;
          rdv[LC_CMD_LO +: 3]      = st_q.last_cmd;
        end
        default: rdv[ROW_W-1:0] = st_q.rows[idx-3];
      endcase
      st_d.pready  = 1'b1;
      st_d.pslverr = (idx < 0) || (pwrite && idx != 1);
      st_d.prdata  = pwrite ? 32'h0000_0000 : rdv;
    end
    if (psel && penable && st_q.pready && pwrite &&
        !st_q.pslverr && paddr == REG_PATTERN) begin
      st_d.pattern = pwdata;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Reset parks the device in precharge power-down with the select stages
  // deasserted, so no command can be decoded until the gate is seen high.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q          <= '0;
      st_q.s1.cke   <= 1'b0;
      st_q.s1.select_n <= 1'b1;
      st_q.s2.select_n <= 1'b1;
      st_q.pwr      <= PWR_PD_PRE;
      st_q.ext_term <= TERM_EN_RST;
      st_q.pattern  <= PATTERN_RST;
      st_q.last_cmd <= CMD_NOP;
      st_q.clk_buf  <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register.
  assign pready     = st_q.pready;
  assign pslverr    = st_q.pslverr;
  assign prdata     = st_q.prdata;
  assign clk_run    = st_q.clk_run;
  assign cmd_buf_en = st_q.cmd_buf;
  assign clk_buf_en = st_q.clk_buf;
  assign out_drv_en = st_q.out_drv;
  assign term_en    = st_q.term;
  assign rd_valid   = st_q.rd_valid;
  assign rd_rise    = st_q.rd_rise;
  assign rd_fall    = st_q.rd_fall;

endmodule : ddrci_top

// ---- ddrci_props.sv ----
// Checker of the control-input block: power gating, reads, termination.
// Assumes it is bound to ddrci_top and sees only that module's ports.
module ddrci_props
  import ddrci_pkg::*;
#(
  parameter int unsigned NBANK = NUM_BANKS
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire ddrci_pins_s pins,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        clk_run,
  input wire logic        cmd_buf_en,
  input wire logic        clk_buf_en,
  input wire logic        out_drv_en,
  input wire ddrci_term_s term_en,
  input wire logic        rd_valid,
  input wire logic [15:0] rd_rise,
  input wire logic [15:0] rd_fall
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic  rd_pin = !pins.select_n && pins.row_strobe_n &&
                       !pins.col_strobe_n && pins.write_en_n && pins.cke;
  // ********
  // Properties
  // ********
  property p_rd; rd_pin && clk_run |-> ##[2:5] rd_valid; endproperty
  property p_desel; pins.select_n |-> ##3 !rd_valid; endproperty
  property p_lanes; term_en == '0 || term_en == '1; endproperty
  property p_pd_term; !cmd_buf_en |-> term_en == '0; endproperty
  property p_self; !clk_buf_en |-> !cmd_buf_en && !out_drv_en; endproperty
  property p_run; clk_run |-> cmd_buf_en && out_drv_en; endproperty
  property p_cke_lo; !pins.cke [*5] |-> !clk_run; endproperty
  property p_cke_hi; pins.cke [*6] |-> clk_run; endproperty
  property p_term_lo; !pins.termination_control [*6] |-> term_en == '0;
  endproperty
  a_rd: assert property (p_rd) else $error("read pulse missing");
  a_desel: assert property (p_desel) else $error("read while off");
  a_lanes: assert property (p_lanes) else $error("lanes differ");
  a_pd_term: assert property (p_pd_term) else $error("term on");
  a_self: assert property (p_self) else $error("buffers on");
  a_run: assert property (p_run) else $error("buffers off");
  a_cke_lo: assert property (p_cke_lo) else $error("still running");
  a_cke_hi: assert property (p_cke_hi) else $error("not running");
  a_term_lo: assert property (p_term_lo) else $error("term stuck");
  c_rd: cover property (rd_valid);
  c_self: cover property (!clk_buf_en);
  c_term: cover property (term_en[0]);
endmodule // ddrci_props

bind ddrci_top ddrci_props #(.NBANK(NBANK)) u_props (
  .core_clk(core_clk), .rst_n(rst_n), .pins(pins), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .clk_run(clk_run), .cmd_buf_en(cmd_buf_en), .clk_buf_en(clk_buf_en),
  .out_drv_en(out_drv_en), .term_en(term_en), .rd_valid(rd_valid),
  .rd_rise(rd_rise), .rd_fall(rd_fall));

// ---- ddrci_ctrl_model.sv ----
// Memory controller model that drives the device pins one cycle per request.
// Assumes requests are held by the bench for exactly one clock.
module ddrci_ctrl_model
  import ddrci_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        cke_req,
  input  wire logic        term_req,
  input  wire logic        go,
  input  wire logic        sel_n_req,
  input  wire logic [2:0]  code_req,
  input  wire logic [1:0]  bank_req,
  input  wire logic [12:0] addr_req,
  output ddrci_pins_s      pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] open_q;
  initial pins = {1'b0, 4'hf, 1'b0, 2'h0, 13'h0};
  initial open_q = 4'h0;
  // Drives a command, or a no-operation with toggling address when idle.
  always @(posedge core_clk) begin
    pins.cke <= cke_req;
    pins.termination_control <= term_req;
    if (go && pins.cke) begin
      pins.select_n <= sel_n_req;
      // Strobes with select form the command code.
      {pins.row_strobe_n, pins.col_strobe_n, pins.write_en_n} <= code_req;
      pins.bank_select <= bank_req;
      pins.addr <= addr_req;
    end else begin
      pins.select_n <= 1'b0;
      {pins.row_strobe_n, pins.col_strobe_n, pins.write_en_n} <= 3'h7;
      pins.bank_select <= ~pins.bank_select;
      pins.addr <= ~pins.addr;
    end
    // Tracks open rows per bank from activates and precharges.
    if (go && !sel_n_req && code_req == 3'h3) begin
      open_q[bank_req] <= 1'b1;
    end
    if (go && !sel_n_req && code_req == 3'h2) begin
      if (addr_req[10]) open_q <= 4'h0;
      else open_q[bank_req] <= 1'b0;
    end
  end
endmodule // ddrci_ctrl_model

// ---- tb_ddr2_x16_control_inputs.sv ----
// Testbench of the control-input block: APB reads and pin commands.
// Assumes the controller model drives the pins and the checker is bound.
module tb_ddr2_x16_control_inputs
  import ddrci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic cke_req = 0, term_req = 0, go = 0, sel_n_req = 1;
  logic [2:0] code_req = 3'h7;
  logic [1:0] bank_req = 2'h0;
  logic [12:0] addr_req = 13'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, clk_run, cmd_buf_en, clk_buf_en, out_drv_en;
  logic rd_valid;
  logic [15:0] rd_rise, rd_fall;
  ddrci_pins_s pins;
  ddrci_term_s term_en;
  int n_mismatch = 0, check_count = 0, n_rd = 0;
  always #20 core_clk = ~core_clk;
  ddrci_ctrl_model mdl (.core_clk(core_clk), .cke_req(cke_req),
    .term_req(term_req), .go(go), .sel_n_req(sel_n_req), .code_req(code_req),
    .bank_req(bank_req), .addr_req(addr_req), .pins(pins));
  ddrci_top #(.NBANK(4)) uut (.core_clk(core_clk), .rst_n(rst_n),
    .pins(pins), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .clk_run(clk_run), .cmd_buf_en(cmd_buf_en),
    .clk_buf_en(clk_buf_en), .out_drv_en(out_drv_en), .term_en(term_en),
    .rd_valid(rd_valid), .rd_rise(rd_rise), .rd_fall(rd_fall));
  // Counts read pulses.
  always @(posedge core_clk) if (rd_valid === 1'b1) n_rd++;
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; waits for pready under a bound.
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel    <= 1;
    penable <= 0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20) n_mismatch++;
  endtask
  task automatic rdchk(string nm, logic [11:0] a, logic [31:0] m,
                       logic [31:0] x);
    apb(0, a, 32'h0);
    chk(nm, r & m, x);
  endtask
  task automatic cmd(logic k, logic s, logic [2:0] c, logic [1:0] b,
                     logic [12:0] a);
    @(posedge core_clk);
    cke_req   <= k;
    go        <= 1;
    sel_n_req <= s;
    code_req  <= c;
    bank_req  <= b;
    addr_req  <= a;
    @(posedge core_clk);
    go <= 0;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin #100us; n_mismatch++; end_of_test(); end
  // ********
  // Tests
  // ********
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1;
    rdchk("pwr_rst", REG_STATUS, 32'h3, 32'h1);
    rdchk("last_rst", REG_LAST_CMD, 32'h70_0000, 32'h10_0000);
    cke_req <= 1;
    repeat (8) @(posedge core_clk);
    chk("clk_run", clk_run, 1);
    chk("drv_run", out_drv_en, 1);
    apb(1, REG_PATTERN, 32'ha5a5_5a5a);
    cmd(1, 0, 3'h3, 2'h2, 13'h1abc);
    rdchk("row2", 12'h018, 32'h1fff, 32'h1abc);
    cmd(1, 0, 3'h5, 2'h2, 13'h3ff);
    chk("rd_cnt", n_rd, 1);
    chk("beats", {rd_fall, rd_rise}, 32'ha5a5_5a5a);
    cmd(1, 1, 3'h5, 2'h2, 13'h0);
    cmd(1, 1, 3'h3, 2'h1, 13'h5);
    chk("rd_desel", n_rd, 1);
    rdchk("open_a", REG_STATUS, 32'hf0, 32'h40);
    cmd(0, 0, 3'h7, 2'h0, 13'h0);
    rdchk("pd_act", REG_STATUS, 32'h3, 32'h2);
    chk("pd_bufs", {cmd_buf_en, clk_buf_en}, 2'h1);
    chk("pd_drv", out_drv_en, 0);
    cmd(1, 0, 3'h7, 2'h0, 13'h0);
    cmd(1, 0, 3'h3, 2'h0, 13'h1);
    cmd(1, 0, 3'h3, 2'h3, 13'h2);
    cmd(1, 0, 3'h2, 2'h2, 13'h1000);
    rdchk("pre_one", REG_STATUS, 32'hf3, 32'h90);
    chk("mdl_open", mdl.open_q, 32'h9);
    cmd(1, 0, 3'h4, 2'h3, 13'h0400);
    rdchk("wr_close", REG_STATUS, 32'hf0, 32'h10);
    rdchk("last_wr", REG_LAST_CMD, 32'h73_1fff, 32'h43_0400);
    cmd(1, 0, 3'h2, 2'h0, 13'h0400);
    rdchk("pre_all", REG_STATUS, 32'hf0, 32'h0);
    cmd(0, 0, 3'h7, 2'h0, 13'h0);
    rdchk("pd_pre", REG_STATUS, 32'h3, 32'h1);
    cmd(1, 0, 3'h7, 2'h0, 13'h0);
    cmd(0, 0, 3'h1, 2'h0, 13'h0);
    rdchk("self", REG_STATUS, 32'h3, 32'h3);
    chk("self_clk", clk_buf_en, 0);
    cmd(1, 0, 3'h7, 2'h0, 13'h0);
    rdchk("self_exit", REG_STATUS, 32'h3, 32'h0);
    cmd(1, 0, 3'h0, 2'h1, 13'h0004);
    rdchk("term_ena", REG_STATUS, 32'h100, 32'h100);
    term_req <= 1;
    cmd(1, 0, 3'h0, 2'h1, 13'h0040);
    chk("term_all", term_en, 32'h3f_ffff);
    rdchk("term_act", REG_STATUS, 32'h200, 32'h200);
    cmd(1, 0, 3'h0, 2'h1, 13'h0);
    chk("term_dis", term_en, 32'h0);
    term_req <= 0;
    rdchk("unmapped", 12'h0fc, 32'hffff_ffff, 32'h0);
    chk("err_map", e, 1);
    apb(1, REG_STATUS, 32'hffff_ffff);
    chk("err_ro", e, 1);
    end_of_test();
  end
endmodule // tb_ddr2_x16_control_inputs
